// ==== ssbp_cfg.svh ====
// Offsets, field positions, encodings and divider counts of the buffered serial port.
`ifndef SSBP_CFG_SVH
`define SSBP_CFG_SVH

`define SSBP_OFF_CTRL1 8'h00
`define SSBP_OFF_CTRL2 8'h04
`define SSBP_OFF_STATUS 8'h08
`define SSBP_OFF_BUF_LO 8'h20
`define SSBP_OFF_BUF_HI 8'h3C

`define SSBP_C1_START 7
`define SSBP_C1_INH 6
`define SSBP_C1_MODE_HI 5
`define SSBP_C1_MODE_LO 3
`define SSBP_C1_SCK_HI 2
`define SSBP_C1_SCK_LO 0

`define SSBP_ST_ACTIVE 0
`define SSBP_ST_SHIFT 1
`define SSBP_ST_WAIT 2

`define SSBP_MODE_TX8 3'h0
`define SSBP_MODE_TX4 3'h2
`define SSBP_MODE_DUP8 3'h4
`define SSBP_MODE_RX8 3'h5
`define SSBP_MODE_RX4 3'h6

`define SSBP_SCK_EXT 3'h7
`define SSBP_CTRL1_RESET 8'h40
`define SSBP_DIV_BASE 10'h004
`define SSBP_BITS4 4'h4
`define SSBP_BITS8 4'h8

`endif

// ==== ssbp_clk_div.sv ====
// Half-period tick divider for the internally generated serial clock.
`timescale 1ns/1ps
`default_nettype none
`include "ssbp_cfg.svh"
module ssbp_clk_div (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Control
  input wire logic run,
  input wire logic [2:0] rateSel,
  // Half-period enable pulse
  output logic tick
);
  logic [9:0] cnt_r;
  logic [9:0] half;

  // Rates 000 to 101 double the half period each step; 110 and 111 reuse the slowest.
  assign half = (rateSel > 3'h5) ? (`SSBP_DIV_BASE << 5) : (`SSBP_DIV_BASE << rateSel);
  assign tick = run && (cnt_r == half - 10'h001);

  always_ff @(posedge sys_clk) begin
    if (!rst_n || !run || tick) begin
      cnt_r <= 10'h000;
    end else begin
      cnt_r <= cnt_r + 10'h001;
    end
  end
endmodule // ssbp_clk_div
`default_nettype wire

// ==== ssbp_peer.sv ====
// Behavioural external serial peripheral sharing the clock line.
`timescale 1ns/1ps
`default_nettype none
module ssbp_peer (
  // Shared line
  input wire logic sckWire,
  input wire logic serialOut,
  // Driven pins
  output var logic sckIn,
  output var logic serialIn
);
  logic [63:0] txBits = 64'h0;
  logic [63:0] rxBits = 64'h0;
  int bitCnt = 0;
  int txIdx = 0;
  initial sckIn = 1'b1;
  initial serialIn = 1'b1;
  task automatic load(input logic [63:0] t);
    txBits = t;
    txIdx = 0;
    rxBits = 64'h0;
    bitCnt = 0;
  endtask
  // The clock stands high between frames; the line is scrambled afterwards.
  task automatic burst(input int n);
    #1.3;
    repeat (n) begin
      #62.5 sckIn = 1'b0;
      #62.5 sckIn = 1'b1;
    end
    #20 serialIn = ~serialIn;
  endtask
  always @(negedge sckWire) begin
    serialIn = txBits[txIdx];
    txIdx = txIdx + 1;
  end
  always @(posedge sckWire) begin
    rxBits = {serialOut, rxBits[63:1]};
    bitCnt = bitCnt + 1;
  end
endmodule // ssbp_peer
`default_nettype wire

// ==== ssbp_pkg.sv ====
// Types shared by the buffered serial port.
package ssbp_pkg;
  typedef logic [7:0] ssbp_word_t;
  typedef enum logic [1:0] {
    SSBP_IDLE,
    SSBP_SHIFT,
    SSBP_WAIT
  } ssbp_state_e;
endpackage

// ==== ssbp_port.sv ====
// Buffered synchronous serial port with an AHB-Lite register slave.
// Summary of operation
// - Words are 4 or 8 bits; 4-bit receive stores zeros in upper nibble.
// - Every word is shifted least significant bit first.
// - A block of one to eight words runs without software help.
// - The done interrupt pulses at each block end, unless the last word is dropped or inhibit or a mode change is written in that cycle.
// - Next buffer word loads at its first bit; block end signals buffer empty.
// - Internal clock transmit waits for new data; any buffer write releases it.
// - Any buffer write, used or not, also releases the wait; a buffer read does not.
// - Clearing start finishes the current word, then clears the active flag.
// - Setting inhibit ends the transfer and clears the active flag at once.
// - External transmit with start set but no fresh data sends dummy, then ends.
// - Receive copies each word into the next buffer; block end signals full.
// - Internal receive waits while data unread; any buffer read releases it.
// - External receive with unread data drops the word and cancels reception.
// - Clearing start during receive stores the current word, then ends.
// - Inhibit during receive stops at once and discards the partial word.
// - Changing the transfer mode clears all buffer contents.
// - Duplex drives on leading edges, samples on trailing, in shared buffers.
// - Internal duplex waits for a transmit write; one write releases the wait.
// - Data changes on falling clock pin edge and is sampled on rising edge.
// - Word count code 000 to 111 selects 1 to 8 words from buffer 0.
`timescale 1ns/1ps
`default_nettype none
`include "ssbp_cfg.svh"
module ssbp_port (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Serial pins
  input wire logic sckIn,
  output logic sckOut,
  output logic sckOe_n,
  input wire logic serialIn,
  output logic serialOut,
  // Block completion event
  output logic blockDoneIrq
);
  ssbp_pkg::ssbp_word_t wordBufferRegs_r [0:7];
  ssbp_pkg::ssbp_state_e state_r;
  logic transferStartBit_r, abortInhibitBit_r, transferActiveFlag_r;
  logic [2:0] transferModeSelect_r, sckSel_r, wordCnt_r, wordIdx_r;
  logic [3:0] bitCnt_r;
  logic [7:0] shift_r, wrAddr_r;
  logic wrPend_r, txFresh_r, rxUnread_r, dummyEnd_r;
  logic sckMeta_r, sckSync_r, sckPrev_r, siMeta_r, siSync_r;
  logic [31:0] hrdata_r;
  logic hreadyout_r, irq_r, sckOut_r, sckOeN_r, serialOut_r;

  // Mode decode.
  wire isTx = (transferModeSelect_r == `SSBP_MODE_TX8) || (transferModeSelect_r == `SSBP_MODE_TX4);
  wire isRx = (transferModeSelect_r == `SSBP_MODE_RX8) || (transferModeSelect_r == `SSBP_MODE_RX4);
  wire isDup = transferModeSelect_r == `SSBP_MODE_DUP8;
  wire fourBit = (transferModeSelect_r == `SSBP_MODE_TX4) || (transferModeSelect_r == `SSBP_MODE_RX4);
  wire [3:0] wordBits = fourBit ? `SSBP_BITS4 : `SSBP_BITS8;
  wire extClk = sckSel_r == `SSBP_SCK_EXT;

  // Bus decode.
  wire addrPhase = hsel && htrans[1] && hready;
  wire wrEn = wrPend_r;
  wire wrIsBuf = (wrAddr_r >= `SSBP_OFF_BUF_LO) && (wrAddr_r <= `SSBP_OFF_BUF_HI);
  wire rdIsBuf = (haddr >= `SSBP_OFF_BUF_LO) && (haddr <= `SSBP_OFF_BUF_HI);
  wire bufWrite = wrEn && wrIsBuf;
  wire bufRead = addrPhase && !hwrite && rdIsBuf;
  wire [2:0] wrBufIdx = wrAddr_r[4:2];
  wire [2:0] rdBufIdx = haddr[4:2];
  wire ctrl1Write = wrEn && (wrAddr_r == `SSBP_OFF_CTRL1);
  wire ctrl2Write = wrEn && (wrAddr_r == `SSBP_OFF_CTRL2);
  wire [2:0] newMode = hwdata[`SSBP_C1_MODE_HI:`SSBP_C1_MODE_LO];
  wire abortNow = ctrl1Write && hwdata[`SSBP_C1_INH];
  wire modeChange = ctrl1Write && (newMode != transferModeSelect_r);
  wire startSet = ctrl1Write && hwdata[`SSBP_C1_START] && !hwdata[`SSBP_C1_INH];

  // Serial clock edges; the pin level is read only after two flip-flops.
  wire divTick;
  wire shifting = state_r == ssbp_pkg::SSBP_SHIFT;
  wire extLead = sckPrev_r && !sckSync_r;
  wire extTrail = !sckPrev_r && sckSync_r;
  wire leadEv = shifting && (extClk ? extLead : (divTick && sckOut_r));
  wire trailEv = shifting && (extClk ? extTrail : (divTick && !sckOut_r));
  wire firstBit = bitCnt_r == 4'h0;
  wire lastBit = bitCnt_r == (wordBits - 4'h1);
  wire wordEnd = trailEv && lastBit;
  wire blockEnd = wordEnd && (wordIdx_r == wordCnt_r);
  wire dummyNow = extClk && !isRx && !txFresh_r && (wordIdx_r == 3'h0);
  wire [7:0] loadVal = dummyNow ? 8'h00 : wordBufferRegs_r[wordIdx_r];
  wire [7:0] rxNext = {siSync_r, shift_r[7:1]};
  wire [7:0] rxWord = fourBit ? {4'h0, rxNext[7:4]} : rxNext;
  wire rxStores = isRx || isDup;
  wire rxCancel = wordEnd && rxStores && extClk && rxUnread_r;
  wire rxStore = wordEnd && rxStores && !rxCancel;
  wire waitHold = isRx ? rxUnread_r : !txFresh_r;

  ssbp_clk_div u_div (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .run(shifting && !extClk),
    .rateSel(sckSel_r),
    .tick(divTick)
  );

  // Pin synchronisers.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sckMeta_r <= 1'b1;
      sckSync_r <= 1'b1;
      sckPrev_r <= 1'b1;
      siMeta_r <= 1'b0;
      siSync_r <= 1'b0;
    end else begin
      sckMeta_r <= sckIn;
      sckSync_r <= sckMeta_r;
      sckPrev_r <= sckSync_r;
      siMeta_r <= serialIn;
      siSync_r <= siMeta_r;
    end
  end

  // Bus slave: zero wait states, reads registered in the address phase.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      wrPend_r <= 1'b0;
      wrAddr_r <= 8'h00;
      hreadyout_r <= 1'b0;
    end else begin
      wrPend_r <= addrPhase && hwrite;
      wrAddr_r <= haddr;
      hreadyout_r <= 1'b1;
    end
  end

  logic [31:0] rdMux;
  always_comb begin
    rdMux = 32'h0000_0000;
    if (rdIsBuf) begin
      rdMux = {24'h000000, wordBufferRegs_r[rdBufIdx]};
    end else if (haddr == `SSBP_OFF_CTRL1) begin
      rdMux = {24'h000000, transferStartBit_r, abortInhibitBit_r, transferModeSelect_r, sckSel_r};
    end else if (haddr == `SSBP_OFF_CTRL2) begin
      rdMux = {29'h00000000, wordCnt_r};
    end else if (haddr == `SSBP_OFF_STATUS) begin
      rdMux = {29'h00000000, state_r == ssbp_pkg::SSBP_WAIT, shifting, transferActiveFlag_r};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      hrdata_r <= 32'h0000_0000;
    end else if (addrPhase && !hwrite) begin
      hrdata_r <= rdMux;
    end
  end

  // Control registers.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      {transferStartBit_r, abortInhibitBit_r, transferModeSelect_r, sckSel_r} <= `SSBP_CTRL1_RESET;
      wordCnt_r <= 3'h0;
    end else begin
      if (ctrl1Write) begin
        {transferStartBit_r, abortInhibitBit_r, transferModeSelect_r, sckSel_r} <= hwdata[7:0];
      end
      if (ctrl2Write) begin
        wordCnt_r <= hwdata[2:0];
      end
    end
  end

  // Word buffers: the engine's store takes priority over a bus write.
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_buf
      always_ff @(posedge sys_clk) begin
        if (!rst_n || modeChange) begin
          wordBufferRegs_r[gi] <= 8'h00;
        end else if (rxStore && (wordIdx_r == 3'(gi))) begin
          wordBufferRegs_r[gi] <= rxWord;
        end else if (bufWrite && (wrBufIdx == 3'(gi))) begin
          wordBufferRegs_r[gi] <= hwdata[7:0];
        end
      end
    end
  endgenerate

  // Data-ready and unread flags; the bus set of the ready flag wins over its block-end clear, the hardware unread set wins over the software clear.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      txFresh_r <= 1'b0;
      rxUnread_r <= 1'b0;
    end else begin
      if (startSet || bufWrite) begin
        txFresh_r <= 1'b1;
      end else if (blockEnd && !isRx) begin
        txFresh_r <= 1'b0;
      end
      if (rxStore && blockEnd) begin
        rxUnread_r <= 1'b1;
      end else if (bufRead || startSet || modeChange) begin
        rxUnread_r <= 1'b0;
      end
    end
  end

  // Transfer sequencer.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_r <= ssbp_pkg::SSBP_IDLE;
      transferActiveFlag_r <= 1'b0;
      wordIdx_r <= 3'h0;
      dummyEnd_r <= 1'b0;
    end else if (abortNow || modeChange) begin
      state_r <= ssbp_pkg::SSBP_IDLE;
      transferActiveFlag_r <= 1'b0;
    end else begin
      case (state_r)
        ssbp_pkg::SSBP_IDLE: begin
          if (startSet) begin
            state_r <= ssbp_pkg::SSBP_SHIFT;
            transferActiveFlag_r <= 1'b1;
            wordIdx_r <= 3'h0;
            dummyEnd_r <= 1'b0;
          end
        end
        ssbp_pkg::SSBP_SHIFT: begin
          if (leadEv && firstBit && dummyNow) begin
            dummyEnd_r <= 1'b1;
          end
          if (wordEnd) begin
            if (rxCancel || dummyEnd_r || !transferStartBit_r) begin
              state_r <= ssbp_pkg::SSBP_IDLE;
              transferActiveFlag_r <= 1'b0;
            end else if (blockEnd) begin
              wordIdx_r <= 3'h0;
              if (!extClk) begin
                state_r <= ssbp_pkg::SSBP_WAIT;
              end
            end else begin
              wordIdx_r <= wordIdx_r + 3'h1;
            end
          end
        end
        ssbp_pkg::SSBP_WAIT: begin
          if (!transferStartBit_r) begin
            state_r <= ssbp_pkg::SSBP_IDLE;
            transferActiveFlag_r <= 1'b0;
          end else if (!waitHold) begin
            state_r <= ssbp_pkg::SSBP_SHIFT;
          end
        end
        default: begin
          state_r <= ssbp_pkg::SSBP_IDLE;
          transferActiveFlag_r <= 1'b0;
        end
      endcase
    end
  end

  // Shift register: word loads at its first leading edge, shifts on each trailing edge.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      shift_r <= 8'h00;
      bitCnt_r <= 4'h0;
    end else if (!shifting) begin
      bitCnt_r <= 4'h0;
    end else begin
      if (leadEv && firstBit) begin
        shift_r <= loadVal;
      end else if (trailEv) begin
        shift_r <= rxNext;
      end
      if (trailEv) begin
        bitCnt_r <= lastBit ? 4'h0 : bitCnt_r + 4'h1;
      end
    end
  end

  // Pin drivers and the block event.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sckOut_r <= 1'b1;
      sckOeN_r <= 1'b1;
      serialOut_r <= 1'b1;
      irq_r <= 1'b0;
    end else begin
      sckOeN_r <= extClk;
      if (!shifting || extClk) begin
        sckOut_r <= 1'b1;
      end else if (divTick) begin
        sckOut_r <= !sckOut_r;
      end
      if (leadEv && !isRx) begin
        serialOut_r <= firstBit ? loadVal[0] : shift_r[0];
      end
      irq_r <= blockEnd && !rxCancel && !abortNow && !modeChange;
    end
  end

  assign hrdata = hrdata_r;
  assign hreadyout = hreadyout_r;
  assign hresp = 1'b0;
  assign sckOut = sckOut_r;
  assign sckOe_n = sckOeN_r;
  assign serialOut = serialOut_r;
  assign blockDoneIrq = irq_r;
endmodule // ssbp_port
`default_nettype wire

// ==== ssbp_port_asserts.sv ====
// Port-level assertions for the buffered serial port.
`timescale 1ns/1ps
`default_nettype none
module ssbp_port_asserts (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Bus answer
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // Serial pins and event
  input wire logic sckOut,
  input wire logic sckOe_n,
  input wire logic serialOut,
  input wire logic blockDoneIrq
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  a_reset_idle: assert property (disable iff (1'b0) !rst_n |=> sckOut && sckOe_n && serialOut
    && !blockDoneIrq) else $error("serial pins not idle after reset");
  a_bus_ready: assert property (rst_n && $past(rst_n) |-> hreadyout)
    else $error("bus inserted a wait state");
  a_bus_okay: assert property (hresp == 1'b0) else $error("bus answered with an error");
  a_upper_zero: assert property (hrdata[31:8] == 24'h000000)
    else $error("read data upper bits not zero");
  a_irq_pulse: assert property (blockDoneIrq |=> !blockDoneIrq)
    else $error("block event longer than one cycle");
  a_irq_on_high: assert property (blockDoneIrq && !sckOe_n |-> sckOut)
    else $error("block event while clock low");
  a_half_period: assert property ($fell(sckOut) && !sckOe_n |=> !sckOut [*3])
    else $error("internal clock low phase too short");
  a_data_steady: assert property (!sckOe_n && !sckOut && $past(sckOut) == 1'b0 |->
    $stable(serialOut)) else $error("data moved while clock low");
endmodule // ssbp_port_asserts
bind ssbp_port ssbp_port_asserts chk_i (.sys_clk(sys_clk), .rst_n(rst_n), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .sckOut(sckOut), .sckOe_n(sckOe_n),
  .serialOut(serialOut), .blockDoneIrq(blockDoneIrq));
`default_nettype wire

// ==== tb_sync_serial_buffered_port.sv ====
// Self-checking bench for the buffered serial port.
`timescale 1ns/1ps
`default_nettype none
`include "ssbp_cfg.svh"
module tb_sync_serial_buffered_port;
  typedef struct packed {logic [2:0] m; logic [2:0] s; logic [2:0] c;} ssbp_row_s;
  localparam logic [63:0] PAT = 64'h96C35AF01E87D24B;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, rd;
  logic hreadyout, hresp, sckIn, sckOut, sckOe_n, serialIn, serialOut, blockDoneIrq;
  wire logic sckWire = sckOe_n ? sckIn : sckOut;
  int error_cnt = 0;
  int checks = 0;
  int cyc = 0;
  int irqCnt = 0;
  ssbp_row_s rows [7];
  ssbp_port dut (.sys_clk(sys_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sckIn(sckIn), .sckOut(sckOut),
    .sckOe_n(sckOe_n), .serialIn(serialIn), .serialOut(serialOut),
    .blockDoneIrq(blockDoneIrq));
  ssbp_peer peer (.sckWire(sckWire), .serialOut(serialOut), .sckIn(sckIn), .serialIn(serialIn));
  always #2.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc++;
    if (blockDoneIrq === 1'b1) irqCnt++;
    if (cyc == 40000) begin
      error_cnt++;
      results();
    end
  end
  task automatic results();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] s);
    checks++;
    if (s !== e) begin
      error_cnt++;
      $display("mismatch %s exp %h got %h", nm, e, s);
    end
  endtask
  // The master holds each phase until hready is sampled high.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    rd = hrdata;
  endtask
  task automatic rdchk(input string nm, input logic [7:0] a, input logic [7:0] e);
    xfer(1'b0, a, 32'h0);
    chk(nm, {56'h0, e}, {32'h0, rd});
  endtask
  task automatic waitIrq(input int n);
    int k;
    k = 0;
    while (irqCnt < n && k < 8000) begin
      @(posedge sys_clk);
      k++;
    end
    chk("irq", 64'(n), 64'(irqCnt));
  endtask
  function automatic logic [7:0] wv(input int i);
    return 8'h3C + 8'(i) * 8'h25;
  endfunction
  initial begin
    logic [7:0] m, c1;
    logic [63:0] expT;
    int n, w, base;
    rows = '{'{`SSBP_MODE_TX8, 3'h0, 3'h0}, '{`SSBP_MODE_TX4, 3'h0, 3'h2},
      '{`SSBP_MODE_RX8, 3'h0, 3'h7}, '{`SSBP_MODE_RX4, 3'h1, 3'h1},
      '{`SSBP_MODE_DUP8, 3'h0, 3'h1}, '{`SSBP_MODE_TX8, 3'h7, 3'h1},
      '{`SSBP_MODE_RX8, 3'h7, 3'h0}};
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    rdchk("ctrl1", `SSBP_OFF_CTRL1, `SSBP_CTRL1_RESET);
    rdchk("ctrl2", `SSBP_OFF_CTRL2, 8'h00);
    rdchk("status", `SSBP_OFF_STATUS, 8'h00);
    rdchk("unmapped", 8'h10, 8'h00);
    xfer(1'b1, `SSBP_OFF_BUF_LO, 32'hA5);
    xfer(1'b1, `SSBP_OFF_CTRL1, {24'h0, 8'h40 | {2'b0, `SSBP_MODE_RX8, 3'h0}});
    rdchk("clear", `SSBP_OFF_BUF_LO, 8'h00);
    for (int r = 0; r < 7; r++) begin
      m = {2'b0, rows[r].m, rows[r].s};
      n = rows[r].c + 1;
      w = (rows[r].m == `SSBP_MODE_TX4 || rows[r].m == `SSBP_MODE_RX4) ? 4 : 8;
      xfer(1'b1, `SSBP_OFF_CTRL1, {24'h0, 8'h40 | m});
      xfer(1'b1, `SSBP_OFF_CTRL2, {29'h0, rows[r].c});
      expT = 64'h0;
      for (int i = 0; i < n; i++) begin
        xfer(1'b1, 8'(`SSBP_OFF_BUF_LO + 4 * i), {24'h0, wv(i)});
        expT |= 64'(wv(i) & (w == 4 ? 8'h0F : 8'hFF)) << (i * w);
      end
      peer.load(PAT);
      base = irqCnt;
      xfer(1'b1, `SSBP_OFF_CTRL1, {24'h0, 8'h80 | m});
      if (rows[r].s == `SSBP_SCK_EXT) peer.burst(n * w);
      waitIrq(base + 1);
      xfer(1'b1, `SSBP_OFF_CTRL1, {24'h0, 8'h40 | m});
      chk("bits", 64'(n * w), 64'(peer.bitCnt));
      if (rows[r].m <= `SSBP_MODE_DUP8)
        chk("txdata", expT, peer.rxBits >> (64 - n * w));
      if (rows[r].m >= `SSBP_MODE_DUP8)
        for (int i = 0; i < n; i++)
          rdchk("rxbuf", 8'(`SSBP_OFF_BUF_LO + 4 * i), 8'(PAT[i * w +: 8] & (w == 4 ? 8'h0F
            : 8'hFF)));
    end
    peer.load(PAT);
    base = irqCnt;
    xfer(1'b1, `SSBP_OFF_CTRL2, 32'h0);
    xfer(1'b1, `SSBP_OFF_CTRL1, 32'h40);
    xfer(1'b1, `SSBP_OFF_BUF_LO, 32'h5A);
    xfer(1'b1, `SSBP_OFF_CTRL1, 32'h80);
    waitIrq(base + 1);
    rdchk("waiting", `SSBP_OFF_STATUS, 8'h05);
    xfer(1'b1, `SSBP_OFF_BUF_HI, 32'h0);
    waitIrq(base + 2);
    chk("repeat", 64'h5A5A, peer.rxBits >> 48);
    xfer(1'b1, `SSBP_OFF_CTRL1, 32'h00);
    // The wait state notices the cleared start bit one cycle after the write lands.
    @(posedge sys_clk);
    rdchk("stopped", `SSBP_OFF_STATUS, 8'h00);
    // Clearing start in mid-word must still finish that word.
    peer.load(PAT);
    xfer(1'b1, `SSBP_OFF_CTRL2, 32'h1);
    xfer(1'b1, `SSBP_OFF_CTRL1, 32'h81);
    repeat (20) @(posedge sys_clk);
    xfer(1'b1, `SSBP_OFF_CTRL1, 32'h01);
    c1 = 8'h01;
    for (int k = 0; k < 300 && c1[0] === 1'b1; k++) begin
      xfer(1'b0, `SSBP_OFF_STATUS, 32'h0);
      c1 = rd[7:0];
    end
    chk("partial", 64'd8, 64'(peer.bitCnt));
    xfer(1'b1, `SSBP_OFF_CTRL1, 32'h47);
    xfer(1'b1, `SSBP_OFF_CTRL1, 32'h87);
    rdchk("active", `SSBP_OFF_STATUS, 8'h03);
    xfer(1'b1, `SSBP_OFF_CTRL1, 32'h47);
    rdchk("inhibit", `SSBP_OFF_STATUS, 8'h00);
    // A reset in mid-word must return the port to its idle settings.
    xfer(1'b1, `SSBP_OFF_CTRL1, 32'h81);
    repeat (30) @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    rdchk("rststat", `SSBP_OFF_STATUS, 8'h00);
    rdchk("rstctrl", `SSBP_OFF_CTRL1, `SSBP_CTRL1_RESET);
    results();
  end
endmodule // tb_sync_serial_buffered_port
`default_nettype wire
